// file: hw/ufc_defines.svh
// Offsets, field positions, reset values and timing counts for the FIFO control mirror block.
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

// =====================================================================
// Configuration index values
`define UFC_IDX_PORT3_MIRROR 8'h19
`define UFC_IDX_PORT4_MIRROR 8'h1a

// =====================================================================
// Runtime register offset from a port base address
`define UFC_FCR_OFFSET 3'h2

// =====================================================================
// Field positions
`define UFC_BIT_FIFO_EN 0
`define UFC_BIT_RX_RST 1
`define UFC_BIT_TX_RST 2
`define UFC_BIT_DMA 3
`define UFC_BIT_THR_LO 6
`define UFC_BIT_THR_HI 7
`define UFC_WRITABLE_MASK 8'hcf

// =====================================================================
// Reset values and threshold levels
`define UFC_MIRROR_RESET 8'h00
`define UFC_THR_CODE0 5'h01
`define UFC_THR_CODE1 5'h04
`define UFC_THR_CODE2 5'h08
`define UFC_THR_CODE3 5'h0e

// =====================================================================
// Base address window and clear cycle count
`define UFC_BASE_MIN 10'h100
`define UFC_BASE_MAX 10'h3f8
`define UFC_FIFO_CLEAR_CYCLES 1

`endif

// file: hw/ufc_pkg.sv
// Types shared by the FIFO control mirror block.
package ufc_pkg;
  typedef enum logic [1:0] {
    UFC_IDLE,
    UFC_CLEAR
  } ufc_clr_state_type;
endpackage

// file: hw/ufc_port_ctrl.sv
// One serial port's runtime FIFO control decode and mirror.
`timescale 1ns/1ps
`include "ufc_defines.svh"

module ufc_port_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  input wire logic [9:0] i_base_addr,
  output logic [7:0] o_mirror,
  output logic o_fifo_en,
  output logic o_rx_clear,
  output logic o_tx_clear,
  output logic [4:0] o_rx_threshold
);

  logic [7:0] mirror_reg;
  logic [7:0] mirror_next;
  logic rx_clr_reg;
  logic rx_clr_next;
  logic tx_clr_reg;
  logic tx_clr_next;
  logic [4:0] thr_reg;
  logic [4:0] thr_next;
  ufc_pkg::ufc_clr_state_type st_reg;
  ufc_pkg::ufc_clr_state_type st_next;
  logic port_on;
  logic hit;

  // =====================================================================
  // Address decode
  always_comb begin
    // A port whose two top base bits are zero is disabled. [RL11]
    port_on = (i_base_addr[9:8] != 2'b00);
    hit = i_io_wr && port_on && (i_io_addr[15:10] == 6'h00) &&
          (i_io_addr[9:3] == i_base_addr[9:3]) &&
          (i_io_addr[2:0] == `UFC_FCR_OFFSET); // [RL3] [RL4]
  end

  // =====================================================================
  // Mirror and clear strobes
  always_comb begin
    mirror_next = mirror_reg;
    rx_clr_next = 1'b0;
    tx_clr_next = 1'b0;
    st_next = st_reg;
    thr_next = thr_reg;
    case (st_reg)
      ufc_pkg::UFC_IDLE: begin
        st_next = ufc_pkg::UFC_IDLE;
      end
      ufc_pkg::UFC_CLEAR: begin
        // The clear strobes last one cycle, then the reset bits drop. [RL6] [RL7] [RL12]
        mirror_next[`UFC_BIT_RX_RST] = 1'b0;
        mirror_next[`UFC_BIT_TX_RST] = 1'b0;
        st_next = ufc_pkg::UFC_IDLE;
      end
      default: begin
        st_next = ufc_pkg::UFC_IDLE;
      end
    endcase
    // A write in the clear cycle is still taken and wins over the self-clear,
    // so no software write to the control register is ever lost. [RL3] [RL4]
    if (hit) begin
      // Reserved bits are masked off so they always read zero. [RL9]
      mirror_next = i_io_wdata & `UFC_WRITABLE_MASK; // [RL3] [RL4] [RL5] [RL8]
      rx_clr_next = i_io_wdata[`UFC_BIT_RX_RST]; // [RL6]
      tx_clr_next = i_io_wdata[`UFC_BIT_TX_RST]; // [RL7]
      if (i_io_wdata[`UFC_BIT_RX_RST] || i_io_wdata[`UFC_BIT_TX_RST]) begin
        st_next = ufc_pkg::UFC_CLEAR;
      end
      case (i_io_wdata[`UFC_BIT_THR_HI:`UFC_BIT_THR_LO]) // [RL10]
        2'b00: thr_next = `UFC_THR_CODE0;
        2'b01: thr_next = `UFC_THR_CODE1;
        2'b10: thr_next = `UFC_THR_CODE2;
        default: thr_next = `UFC_THR_CODE3;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mirror_reg <= `UFC_MIRROR_RESET;
      rx_clr_reg <= 1'b0;
      tx_clr_reg <= 1'b0;
      thr_reg <= `UFC_THR_CODE0;
      st_reg <= ufc_pkg::UFC_IDLE;
    end else begin
      mirror_reg <= mirror_next;
      rx_clr_reg <= rx_clr_next;
      tx_clr_reg <= tx_clr_next;
      thr_reg <= thr_next;
      st_reg <= st_next;
    end
  end

  // The DMA bit is stored only for readback and drives nothing. [RL8]
  assign o_mirror = mirror_reg;
  assign o_fifo_en = mirror_reg[`UFC_BIT_FIFO_EN]; // [RL5]
  assign o_rx_clear = rx_clr_reg;
  assign o_tx_clear = tx_clr_reg;
  assign o_rx_threshold = thr_reg;

endmodule

// file: hw/ufc_mirror_top.sv
// Top of the third and fourth port FIFO control mirror registers.
//
// What this block does
// RL1 - Port three mirror readable only in configuration state with index 19h.
// RL2 - Port four mirror readable only in configuration state with index 1Ah.
// RL3 - Port three mirror is read-only, updated by writes to base plus two.
// RL4 - Port four mirror is read-only, updated by writes to base plus two.
// RL5 - Bit zero enables both FIFOs and shows in the mirror.
// RL6 - Bit one empties receive FIFO, clears counters, then self-clears.
// RL7 - Bit two empties transmit FIFO, zeroes counters, then self-clears.
// RL8 - DMA mode bit is stored but changes nothing in port operation.
// RL9 - Mirror bits four and five always read zero.
// RL10 - Bits seven and six pick receive threshold 1, 4, 8 or 14 bytes.
// RL11 - Software places ports on 8-byte bounds; top bits zero disables port.
// RL12 - Mirror shows zero in bits one and two after the clear completes.
`timescale 1ns/1ps
`include "ufc_defines.svh"

module ufc_mirror_top (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_cfg_state,
  input wire logic [7:0] i_config_select_index,
  input wire logic i_cfg_rd,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  input wire logic [9:0] i_port3_base,
  input wire logic [9:0] i_port4_base,
  output logic [7:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  output logic o_port3_fifo_en,
  output logic o_port3_rx_clear,
  output logic o_port3_tx_clear,
  output logic [4:0] o_port3_rx_threshold,
  output logic o_port4_fifo_en,
  output logic o_port4_rx_clear,
  output logic o_port4_tx_clear,
  output logic [4:0] o_port4_rx_threshold
);

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [9:0] port_base [2];
  logic [7:0] port_mirror [2];
  logic port_fifo_en [2];
  logic port_rx_clear [2];
  logic port_tx_clear [2];
  logic [4:0] port_rx_threshold [2];

  // =====================================================================
  // Port instances
  // Entry 0 serves the third port and entry 1 the fourth; each decodes the shared bus itself.
  assign port_base[0] = i_port3_base;
  assign port_base[1] = i_port4_base;

  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      ufc_port_ctrl u_port (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_io_addr(i_io_addr),
        .i_io_wr(i_io_wr),
        .i_io_wdata(i_io_wdata),
        .i_base_addr(port_base[p]),
        .o_mirror(port_mirror[p]),
        .o_fifo_en(port_fifo_en[p]),
        .o_rx_clear(port_rx_clear[p]),
        .o_tx_clear(port_tx_clear[p]),
        .o_rx_threshold(port_rx_threshold[p])
      );
    end
  endgenerate

  assign o_port3_fifo_en = port_fifo_en[0];
  assign o_port3_rx_clear = port_rx_clear[0];
  assign o_port3_tx_clear = port_tx_clear[0];
  assign o_port3_rx_threshold = port_rx_threshold[0];
  assign o_port4_fifo_en = port_fifo_en[1];
  assign o_port4_rx_clear = port_rx_clear[1];
  assign o_port4_tx_clear = port_tx_clear[1];
  assign o_port4_rx_threshold = port_rx_threshold[1];

  // =====================================================================
  // Configuration read path
  // Outside configuration state or on another index the data reads zero, so a
  // stray read cannot leak the mirrors.
  always_comb begin
    rdata_next = 8'h00;
    rvalid_next = 1'b0;
    if (i_cfg_rd) begin
      rvalid_next = 1'b1;
      if (i_cfg_state && (i_config_select_index == `UFC_IDX_PORT3_MIRROR)) begin
        rdata_next = port_mirror[0]; // [RL1]
      end else if (i_cfg_state && (i_config_select_index == `UFC_IDX_PORT4_MIRROR)) begin
        rdata_next = port_mirror[1]; // [RL2]
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_cfg_rdata = rdata_reg;
  assign o_cfg_rvalid = rvalid_reg;

endmodule

// file: verification/ufc_mirror_checker.sv
// Port assertions for the FIFO control mirror top.
`timescale 1ns/1ps
module ufc_mirror_checker (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_cfg_state,
  input wire logic [7:0] i_config_select_index,
  input wire logic i_cfg_rd,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  input wire logic [9:0] i_port3_base,
  input wire logic [9:0] i_port4_base,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic o_cfg_rvalid,
  input wire logic o_port3_fifo_en,
  input wire logic o_port3_rx_clear,
  input wire logic o_port4_tx_clear,
  input wire logic [4:0] o_port3_rx_threshold
);
  // =====================================================================
  // Write decode
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  logic w3;
  logic w4;
  // Write strobes for the control register of each port, from base plus two.
  assign w3 = i_io_wr && i_io_addr == {6'h00, i_port3_base[9:3], 3'h2} && |i_port3_base[9:8];
  assign w4 = i_io_wr && i_io_addr == {6'h00, i_port4_base[9:3], 3'h2} && |i_port4_base[9:8];
  sequence s_one(x);
    x ##1 !x;
  endsequence
  property p_rv; i_cfg_rd |=> o_cfg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");
  property p_rz; i_cfg_rd && !i_cfg_state |=> o_cfg_rdata == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("read outside config state");
  property p_rsv; o_cfg_rvalid |-> o_cfg_rdata[5:4] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_en; w3 |=> o_port3_fifo_en == $past(i_io_wdata[0]); endproperty
  a_en: assert property (p_en) else $error("fifo enable wrong");
  property p_rx; w3 && i_io_wdata[1] ##1 !w3 |-> s_one(o_port3_rx_clear); endproperty
  a_rx: assert property (p_rx) else $error("rx clear pulse wrong");
  property p_tx; w4 && i_io_wdata[2] ##1 !w4 |-> s_one(o_port4_tx_clear); endproperty
  a_tx: assert property (p_tx) else $error("tx clear pulse wrong");
  property p_thr; w3 && i_io_wdata[7:6] == 2'h3 |=> o_port3_rx_threshold == 5'h0e; endproperty
  a_thr: assert property (p_thr) else $error("threshold wrong");
  property p_idle; !i_io_wr |=> !o_port3_rx_clear; endproperty
  a_idle: assert property (p_idle) else $error("clear without write");
  property p_idx;
    i_cfg_rd && (i_config_select_index != 8'h19) && (i_config_select_index != 8'h1a)
      |=> o_cfg_rdata == 8'h00;
  endproperty
  a_idx: assert property (p_idx) else $error("read on foreign index");
endmodule
bind ufc_mirror_top ufc_mirror_checker u_chk (
  .i_clk_sys(i_clk_sys),
  .i_srst(i_srst),
  .i_cfg_state(i_cfg_state),
  .i_config_select_index(i_config_select_index),
  .i_cfg_rd(i_cfg_rd),
  .i_io_addr(i_io_addr),
  .i_io_wr(i_io_wr),
  .i_io_wdata(i_io_wdata),
  .i_port3_base(i_port3_base),
  .i_port4_base(i_port4_base),
  .o_cfg_rdata(o_cfg_rdata),
  .o_cfg_rvalid(o_cfg_rvalid),
  .o_port3_fifo_en(o_port3_fifo_en),
  .o_port3_rx_clear(o_port3_rx_clear),
  .o_port4_tx_clear(o_port4_tx_clear),
  .o_port3_rx_threshold(o_port3_rx_threshold)
);

// file: verification/ufc_host_model.sv
// Host software model driving runtime writes and configuration reads.
`timescale 1ns/1ps
module ufc_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output logic o_cfg_state,
  output logic [7:0] o_index,
  output logic o_cfg_rd,
  output logic [15:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  initial begin
    o_cfg_state = 1'b1;
    o_index = 8'h00;
    o_cfg_rd = 1'b0;
    o_addr = 16'hffff;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_wr = 1'b0;
    // Released lines show the inverse so a stale value cannot pass for a hold.
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic cfg(input logic s);
    @(posedge i_clk_sys);
    #1;
    o_cfg_state = s;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    @(posedge i_clk_sys);
    #1;
    o_index = idx;
    o_cfg_rd = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_cfg_rd = 1'b0;
    q = i_rdata;
  endtask
endmodule

// file: verification/ufc_mirror_top_tb.sv
// Self-checking bench for the FIFO control mirror top.
`timescale 1ns/1ps
module ufc_mirror_top_tb;
  typedef struct packed {logic [7:0] w; logic [7:0] m; logic [4:0] t;} ufc_row_type;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cs, rd, wr, rv, en3, rc3, tc3, en4, rc4, tc4;
  logic [7:0] idx, wd, q, rdat;
  logic [15:0] ad;
  logic [4:0] th3, th4;
  logic [9:0] b3 = 10'h2f8;
  logic [9:0] b4 = 10'h3e8;
  int bad_count = 0;
  int checks = 0;
  ufc_row_type rows [5] = '{'{8'h01, 8'h01, 5'h01}, '{8'h79, 8'h49, 5'h04},
    '{8'h88, 8'h88, 5'h08}, '{8'hc1, 8'hc1, 5'h0e}, '{8'h30, 8'h00, 5'h01}};
  always #4 clk = ~clk;
  ufc_mirror_top dut (.i_clk_sys(clk), .i_srst(srst), .i_cfg_state(cs),
    .i_config_select_index(idx), .i_cfg_rd(rd), .i_io_addr(ad), .i_io_wr(wr),
    .i_io_wdata(wd), .i_port3_base(b3), .i_port4_base(b4), .o_cfg_rdata(rdat),
    .o_cfg_rvalid(rv), .o_port3_fifo_en(en3), .o_port3_rx_clear(rc3),
    .o_port3_tx_clear(tc3), .o_port3_rx_threshold(th3), .o_port4_fifo_en(en4),
    .o_port4_rx_clear(rc4), .o_port4_tx_clear(tc4), .o_port4_rx_threshold(th4));
  ufc_host_model host (.i_clk_sys(clk), .i_rdata(rdat), .o_cfg_state(cs), .o_index(idx),
    .o_cfg_rd(rd), .o_addr(ad), .o_wr(wr), .o_wdata(wd));
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // =====================================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    host.rd(8'h19, q);
    cmp8("reset mirror", 8'h00, q);
    cmp8("reset thr", 8'h01, {3'h0, th3});
    cmp8("read valid", 8'h01, {7'h00, rv});
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      host.wr({6'h00, b3[9:3], 3'h2}, rows[i].w);
      host.wr({6'h00, b4[9:3], 3'h2}, rows[i].w);
      host.rd(8'h19, q);
      cmp8("mirror3", rows[i].m, q);
      host.rd(8'h1a, q);
      cmp8("mirror4", rows[i].m, q);
      cmp8("thr4", {3'h0, rows[i].t}, {3'h0, th4});
      cmp8("en3", {7'h00, rows[i].m[0]}, {7'h00, en3});
      cmp8("en4", {7'h00, rows[i].m[0]}, {7'h00, en4});
      cmp8("thr3", {3'h0, rows[i].t}, {3'h0, th3});
    end
    $display("test table done");
    host.wr({6'h00, b3[9:3], 3'h2}, 8'h87);
    cmp8("rx clear", 8'h01, {7'h00, rc3});
    cmp8("tx clear3", 8'h01, {7'h00, tc3});
    host.rd(8'h19, q);
    cmp8("mirror3 after clear", 8'h81, q);
    cmp8("rx clear drop", 8'h00, {7'h00, rc3});
    host.wr({6'h00, b4[9:3], 3'h2}, 8'h06);
    cmp8("rx clear4", 8'h01, {7'h00, rc4});
    cmp8("tx clear", 8'h01, {7'h00, tc4});
    host.rd(8'h1a, q);
    cmp8("mirror4 after clear", 8'h00, q);
    $display("test clear done");
    host.cfg(1'b0);
    host.rd(8'h19, q);
    cmp8("read outside config", 8'h00, q);
    host.cfg(1'b1);
    host.rd(8'h1b, q);
    cmp8("read other index", 8'h00, q);
    host.wr({6'h00, b3[9:3], 3'h3}, 8'hc1);
    b3 = 10'h0f8;
    host.wr({6'h00, b3[9:3], 3'h2}, 8'h01);
    host.rd(8'h19, q);
    cmp8("mirror3 unchanged", 8'h81, q);
    $display("test refusal done");
    @(posedge clk);
    #1;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    host.rd(8'h19, q);
    cmp8("mirror3 after reset", 8'h00, q);
    cmp8("en3 after reset", 8'h00, {7'h00, en3});
    cmp8("thr3 after reset", 8'h01, {3'h0, th3});
    $display("test mid reset done");
    summarize();
  end
  initial begin
    #20000;
    bad_count++;
    summarize();
  end
endmodule
